//--- src/tdoc_pkg.sv
/*
  tdoc_pkg: register map, field layout and reset values of the trim
  output control block.
  assumes: included before every design file that uses it.
*/
package tdoc_pkg;
  // -------------------------------------------------------------------
  // sizes
  // -------------------------------------------------------------------
  localparam int unsigned N_LARGE  = 12;
  localparam int unsigned N_SMALL  = 8;
  localparam int unsigned CODE_W   = 8;
  localparam int unsigned RANGE_W  = 2;
  localparam int unsigned FIELDS   = 4;

  // -------------------------------------------------------------------
  // default page offsets
  // -------------------------------------------------------------------
  localparam logic [7:0] OFS_CODE_FIRST = 8'h00;
  localparam logic [7:0] OFS_CODE_LAST  = 8'h0b;
  localparam logic [7:0] OFS_RANGE_A    = 8'h12;
  localparam logic [7:0] OFS_RANGE_B    = 8'h13;
  localparam logic [7:0] OFS_RANGE_C    = 8'h14;

  // -------------------------------------------------------------------
  // extended page offsets
  // -------------------------------------------------------------------
  localparam logic [7:0] OFS_ENABLE_LOW  = 8'h1c;
  localparam logic [7:0] OFS_ENABLE_HIGH = 8'h1d;
  localparam logic [7:0] ENABLE_HIGH_MASK = 8'h0f;

  // -------------------------------------------------------------------
  // reset values
  // -------------------------------------------------------------------
  localparam logic [7:0] RST_CODE   = 8'h00;
  localparam logic [7:0] RST_RANGE  = 8'h00;
  localparam logic [7:0] RST_ENABLE = 8'h00;

  // -------------------------------------------------------------------
  // output span encodings, limits in millivolts
  // -------------------------------------------------------------------
  typedef enum logic [1:0] {
    TDOC_SPAN_OFF  = 2'h0,
    TDOC_SPAN_LOW  = 2'h1,
    TDOC_SPAN_MID  = 2'h2,
    TDOC_SPAN_HIGH = 2'h3
  } tdoc_span_t;

  localparam int unsigned SPAN_LOW_MIN_MV  = 400;
  localparam int unsigned SPAN_LOW_MAX_MV  = 800;
  localparam int unsigned SPAN_MID_MIN_MV  = 600;
  localparam int unsigned SPAN_MID_MAX_MV  = 1200;
  localparam int unsigned SPAN_HIGH_MIN_MV = 800;
  localparam int unsigned SPAN_HIGH_MAX_MV = 1600;
endpackage : tdoc_pkg

//--- src/tdoc_channel.sv
/*
  tdoc_channel: output stage control of one trim output.
  assumes: enable, range and code come from the register file.
*/
`timescale 1ns/100ps
`default_nettype none
module tdoc_channel
(
  input  wire logic                               clk_in,
  input  wire logic                               reset_in,
  input  wire logic                               enable_in,
  input  wire logic [tdoc_pkg::RANGE_W-1:0]       range_in,
  input  wire logic [tdoc_pkg::CODE_W-1:0]        code_in,
  output logic                                    drive_out,
  output logic                                    buffer_on_out,
  output logic [tdoc_pkg::RANGE_W-1:0]            span_out,
  output logic [tdoc_pkg::CODE_W-1:0]             level_out
);
  logic buffer_on_d;

  // zero range field switches the buffer off
  assign buffer_on_d = (range_in != tdoc_pkg::TDOC_SPAN_OFF); // RULE5

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      drive_out     <= 1'b0; // RULE1
      buffer_on_out <= 1'b0;
      span_out      <= tdoc_pkg::TDOC_SPAN_OFF;
      level_out     <= tdoc_pkg::RST_CODE;
    end
    else
    begin
      drive_out     <= enable_in & buffer_on_d; // RULE2 RULE15
      buffer_on_out <= buffer_on_d;
      span_out      <= range_in; // RULE3 RULE4
      level_out     <= code_in; // RULE11
    end
  end
endmodule : tdoc_channel
`default_nettype wire

//--- src/tdoc_top.sv
/*
  tdoc_top: register file and output control for the trim output bank.
  assumes: a serial interface front end issues single-cycle register
  strobes synchronous to clk_in; boot logic presents restored range data.
*/
// Operation
// (RULE1) every trim output is high impedance from power-up until enabled
// (RULE2) an output whose enable bit is zero stays high impedance
// (RULE3) each output offers three spans: 0.4-0.8, 0.6-1.2, 0.8-1.6 volts
// (RULE4) range code 01 low span, 10 middle span, 11 high span
// (RULE5) a zero range field or register switches the output buffer off
// (RULE6) three range registers, four 2-bit fields each, outputs 1-4, 5-8, 9-12
// (RULE7) boot restores range configuration but never the enable bits
// (RULE8) software enables each needed output after power-up in extended page
// (RULE9) first enable register bits 0-7 enable outputs 1-8
// (RULE10) second enable register bits 0-3 enable outputs 9-12, bits 7-4 reserved
// (RULE11) one 8-bit code register per output sets its level
// (RULE12) code registers are volatile and clear to zero on reset
// (RULE13) software keeps codes between 07h and F8h; 80h is centre
// (RULE14) large variant has 12 outputs, small variant 8
// (RULE15) an output drives only when enabled and its range is nonzero
`timescale 1ns/100ps
`default_nettype none
module tdoc_top
#(
  parameter bit LARGE_VARIANT = 1'b1
)
(
  input  wire logic                 clk_in,
  input  wire logic                 reset_in,
  input  wire logic                 reg_wr_in,
  input  wire logic                 reg_rd_in,
  input  wire logic                 reg_page_in,
  input  wire logic [7:0]           reg_addr_in,
  input  wire logic [7:0]           reg_wdata_in,
  output logic      [7:0]           reg_rdata_out,
  output logic                      reg_rvalid_out,
  input  wire logic                 boot_load_in,
  input  wire logic [23:0]          boot_range_in,
  output logic      [11:0]          trim_drive_out,
  output logic      [11:0]          trim_buffer_on_out,
  output logic      [23:0]          trim_span_out,
  output logic      [95:0]          trim_level_out
);
  localparam int unsigned NUM_OUT =
    LARGE_VARIANT ? tdoc_pkg::N_LARGE : tdoc_pkg::N_SMALL; // RULE14

  logic [7:0]  code_q [tdoc_pkg::N_LARGE];
  logic [7:0]  range_q [3];
  logic [7:0]  en_low_q;
  logic [7:0]  en_high_q;
  logic [11:0] en_all;
  logic [23:0] range_all;
  logic        wr_dflt;
  logic        wr_ext;

  // -------------------------------------------------------------------
  // address decoding
  // -------------------------------------------------------------------
  function automatic logic is_code(input logic [7:0] a);
    is_code = (a <= tdoc_pkg::OFS_CODE_LAST) &&
              (a < 8'(tdoc_pkg::OFS_CODE_FIRST + 8'(NUM_OUT)));
  endfunction : is_code

  function automatic logic is_range(input logic [7:0] a);
    is_range = (a == tdoc_pkg::OFS_RANGE_A) || (a == tdoc_pkg::OFS_RANGE_B) ||
               ((a == tdoc_pkg::OFS_RANGE_C) && LARGE_VARIANT);
  endfunction : is_range

  assign wr_dflt = reg_wr_in & ~reg_page_in;
  assign wr_ext  = reg_wr_in & reg_page_in;

  // -------------------------------------------------------------------
  // output code registers
  // -------------------------------------------------------------------
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      for (int i = 0; i < tdoc_pkg::N_LARGE; i++)
      begin
        code_q[i] <= tdoc_pkg::RST_CODE; // RULE12
      end
    end
    else if (wr_dflt && is_code(reg_addr_in))
    begin
      code_q[reg_addr_in[3:0]] <= reg_wdata_in; // RULE11
    end
  end

  // -------------------------------------------------------------------
  // range registers, restored at boot
  // -------------------------------------------------------------------
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      for (int i = 0; i < 3; i++)
      begin
        range_q[i] <= tdoc_pkg::RST_RANGE;
      end
    end
    else if (wr_dflt && is_range(reg_addr_in))
    begin
      range_q[2'(reg_addr_in - tdoc_pkg::OFS_RANGE_A)] <= reg_wdata_in; // RULE6
    end
    else if (boot_load_in)
    begin
      range_q[0] <= boot_range_in[7:0];
      range_q[1] <= boot_range_in[15:8];
      range_q[2] <= LARGE_VARIANT ? boot_range_in[23:16] : tdoc_pkg::RST_RANGE;
    end
  end

  // -------------------------------------------------------------------
  // enable registers, extended page, never loaded at boot
  // -------------------------------------------------------------------
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      en_low_q  <= tdoc_pkg::RST_ENABLE; // RULE7
      en_high_q <= tdoc_pkg::RST_ENABLE;
    end
    else if (wr_ext && reg_addr_in == tdoc_pkg::OFS_ENABLE_LOW)
    begin
      en_low_q <= reg_wdata_in; // RULE9
    end
    else if (wr_ext && reg_addr_in == tdoc_pkg::OFS_ENABLE_HIGH && LARGE_VARIANT)
    begin
      en_high_q <= reg_wdata_in & tdoc_pkg::ENABLE_HIGH_MASK; // RULE10
    end
  end

  // -------------------------------------------------------------------
  // read port, unmapped reads return zero
  // -------------------------------------------------------------------
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      reg_rdata_out  <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end
    else
    begin
      reg_rvalid_out <= reg_rd_in;
      if (!reg_rd_in)
        reg_rdata_out <= 8'h00;
      else if (reg_page_in)
        reg_rdata_out <= (reg_addr_in == tdoc_pkg::OFS_ENABLE_LOW)  ? en_low_q :
                         (reg_addr_in == tdoc_pkg::OFS_ENABLE_HIGH) ? en_high_q : 8'h00;
      else if (is_code(reg_addr_in))
        reg_rdata_out <= code_q[reg_addr_in[3:0]];
      else if (is_range(reg_addr_in))
        reg_rdata_out <= range_q[2'(reg_addr_in - tdoc_pkg::OFS_RANGE_A)];
      else
        reg_rdata_out <= 8'h00;
    end
  end

  // -------------------------------------------------------------------
  // output channels
  // -------------------------------------------------------------------
  assign en_all    = {en_high_q[3:0], en_low_q};
  assign range_all = {range_q[2], range_q[1], range_q[0]};

  generate
    for (genvar g = 0; g < tdoc_pkg::N_LARGE; g++)
    begin : g_ch
      if (g < NUM_OUT)
      begin : g_used
        tdoc_channel u_ch
        (
          .clk_in        (clk_in),
          .reset_in      (reset_in),
          .enable_in     (en_all[g]),
          .range_in      (range_all[2*g +: 2]),
          .code_in       (code_q[g]),
          .drive_out     (trim_drive_out[g]),
          .buffer_on_out (trim_buffer_on_out[g]),
          .span_out      (trim_span_out[2*g +: 2]),
          .level_out     (trim_level_out[8*g +: 8])
        );
      end
      else
      begin : g_absent
        assign trim_drive_out[g]        = 1'b0; // RULE14
        assign trim_buffer_on_out[g]    = 1'b0;
        assign trim_span_out[2*g +: 2]  = 2'h0;
        assign trim_level_out[8*g +: 8] = 8'h00;
      end
    end
  endgenerate

  // -------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------
  property p_hiz_until_enable;
    @(posedge clk_in) disable iff (reset_in)
    (en_all == 12'h000) ##1 (en_all == 12'h000) |-> (trim_drive_out == 12'h000);
  endproperty
  a_hiz_until_enable: assert property (p_hiz_until_enable) // RULE1
    else $error("output drives with no enable set");

  property p_disabled_hiz;
    @(posedge clk_in) disable iff (reset_in)
    !en_all[0] |=> !trim_drive_out[0];
  endproperty
  a_disabled_hiz: assert property (p_disabled_hiz) // RULE2
    else $error("output 1 drives while disabled");

  property p_span_follows;
    @(posedge clk_in) disable iff (reset_in)
    (range_q[0][3:2] == 2'h2) |=> (trim_span_out[3:2] == 2'h2);
  endproperty
  a_span_follows: assert property (p_span_follows) // RULE4
    else $error("output 2 span does not follow its field");

  property p_zero_range_off;
    @(posedge clk_in) disable iff (reset_in)
    (wr_dflt && reg_addr_in == tdoc_pkg::OFS_RANGE_A && reg_wdata_in == 8'h00
     && !boot_load_in) |=> ##1 (trim_buffer_on_out[3:0] == 4'h0);
  endproperty
  a_zero_range_off: assert property (p_zero_range_off) // RULE5
    else $error("buffers stay on after range cleared");

  property p_field_map;
    @(posedge clk_in) disable iff (reset_in)
    (range_q[1][1:0] == 2'h0) |=> !trim_buffer_on_out[4] && !trim_drive_out[4];
  endproperty
  a_field_map: assert property (p_field_map) // RULE6
    else $error("output 5 on with zero field");

  property p_boot_keeps_enables;
    @(posedge clk_in) disable iff (reset_in)
    (boot_load_in && !wr_ext) |=> $stable(en_low_q) && $stable(en_high_q);
  endproperty
  a_boot_keeps_enables: assert property (p_boot_keeps_enables) // RULE7
    else $error("boot changed enable bits");

  property p_enable_low_write;
    @(posedge clk_in) disable iff (reset_in)
    (wr_ext && reg_addr_in == tdoc_pkg::OFS_ENABLE_LOW) |=>
      (en_low_q == $past(reg_wdata_in));
  endproperty
  a_enable_low_write: assert property (p_enable_low_write) // RULE9
    else $error("enable low write lost");

  property p_reserved_zero;
    @(posedge clk_in) disable iff (reset_in)
    en_high_q[7:4] == 4'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // RULE10
    else $error("reserved enable bits set");

  property p_code_to_level;
    @(posedge clk_in) disable iff (reset_in)
    (wr_dflt && reg_addr_in == tdoc_pkg::OFS_CODE_FIRST) |=> ##1
      (trim_level_out[7:0] == $past(reg_wdata_in, 2));
  endproperty
  a_code_to_level: assert property (p_code_to_level) // RULE11
    else $error("output 1 level does not follow code write");

  property p_code_clear;
    @(posedge clk_in) $fell(reset_in) |-> (code_q[0] == 8'h00) && (code_q[11] == 8'h00);
  endproperty
  a_code_clear: assert property (p_code_clear) // RULE12
    else $error("code not cleared by reset");

  property p_variant;
    @(posedge clk_in) disable iff (reset_in)
    !LARGE_VARIANT |-> (trim_drive_out[11:8] == 4'h0);
  endproperty
  a_variant: assert property (p_variant) // RULE14
    else $error("absent output drives on small variant");

  property p_drive_cause;
    @(posedge clk_in) disable iff (reset_in)
    trim_drive_out[7] |-> $past(en_all[7]) && ($past(range_q[1][7:6]) != 2'h0);
  endproperty
  a_drive_cause: assert property (p_drive_cause) // RULE15
    else $error("output 8 drives without enable and range");

  c_enable_one: cover property (@(posedge clk_in) disable iff (reset_in)
    $rose(trim_drive_out[0]));
  c_high_drive: cover property (@(posedge clk_in) disable iff (reset_in)
    trim_drive_out[11]);
  c_read_enable: cover property (@(posedge clk_in) disable iff (reset_in)
    reg_rvalid_out && reg_rdata_out != 8'h00);
endmodule : tdoc_top
`default_nettype wire

//--- test/tdoc_trim_node.sv
/*
  tdoc_trim_node: far-side trim node that each trim output feeds.
  assumes: fed by the trim outputs of tdoc_top; the node has no pull.
*/
`timescale 1ns/100ps
`default_nettype none
module tdoc_trim_node
(
  input  wire logic        clk_in,
  input  wire logic [11:0] drive_in,
  input  wire logic [95:0] level_in,
  output logic      [95:0] node_out
);
  logic [95:0] node_q = 96'h0;

  // undriven node wanders: inverse of last value each cycle
  always @(posedge clk_in)
  begin
    for (int i = 0; i < 12; i++)
    begin
      if (drive_in[i])
        node_q[8*i +: 8] <= level_in[8*i +: 8];
      else
        node_q[8*i +: 8] <= ~node_q[8*i +: 8];
    end
  end
  assign node_out = node_q;
endmodule : tdoc_trim_node
`default_nettype wire

//--- test/tdoc_top_test.sv
/*
  tdoc_top_test: self-checking bench for the trim output control block.
  assumes: tdoc_pkg, tdoc_top and tdoc_trim_node are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module tdoc_top_test;
  typedef struct packed
  {
    logic       page;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rexp;
  } tdoc_row_t;

  logic        clk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        page = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic        boot = 1'b0;
  logic [23:0] boot_rng = 24'h000000;
  logic [7:0]  rdata_l, rdata_s;
  logic        rvalid_l;
  logic [11:0] drive_l, buf_l, drive_s, buf_s;
  logic [23:0] span_l, span_s;
  logic [95:0] level_l, node;
  int          fail_count = 0;
  int          comparisons = 0;
  int          cycles = 0;
  tdoc_row_t   rows [11];

  always #20 clk_in = ~clk_in;

  tdoc_top #(.LARGE_VARIANT(1'b1)) i_tdoc_top
  (
    .clk_in(clk_in), .reset_in(reset_in), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_page_in(page), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_rdata_out(rdata_l), .reg_rvalid_out(rvalid_l), .boot_load_in(boot),
    .boot_range_in(boot_rng), .trim_drive_out(drive_l), .trim_buffer_on_out(buf_l),
    .trim_span_out(span_l), .trim_level_out(level_l)
  );

  tdoc_top #(.LARGE_VARIANT(1'b0)) i_tdoc_top_small
  (
    .clk_in(clk_in), .reset_in(reset_in), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_page_in(page), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_rdata_out(rdata_s), .reg_rvalid_out(), .boot_load_in(boot),
    .boot_range_in(boot_rng), .trim_drive_out(drive_s), .trim_buffer_on_out(buf_s),
    .trim_span_out(span_s), .trim_level_out()
  );

  tdoc_trim_node i_tdoc_trim_node
  (
    .clk_in(clk_in), .drive_in(drive_l), .level_in(level_l), .node_out(node)
  );

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic end_sim;
    $display("counts: comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [95:0] e, input logic [95:0] g);
    comparisons++;
    if (g !== e)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic tick;
    @(posedge clk_in);
    #1;
  endtask : tick

  task automatic req(input logic w, input logic r, input logic p, input logic [7:0] a,
                     input logic [7:0] d);
    wr = w;
    rd = r;
    page = p;
    addr = a;
    wdata = d;
  endtask : req

  task automatic wr_reg(input logic p, input logic [7:0] a, input logic [7:0] d);
    tick;
    req(1'b1, 1'b0, p, a, d);
    tick;
    req(1'b0, 1'b0, p, a, d);
  endtask : wr_reg

  task automatic rd_reg(input logic p, input logic [7:0] a);
    tick;
    req(1'b0, 1'b1, p, a, 8'h00);
    tick;
    chk("rvalid", 1'b1, rvalid_l);
    rd = 1'b0;
  endtask : rd_reg

  function automatic logic [11:0] f_drive(input logic [11:0] en, input logic [23:0] rng);
    for (int i = 0; i < 12; i++)
      f_drive[i] = en[i] & (rng[2*i +: 2] != 2'h0);
  endfunction : f_drive

  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fail_count++;
      end_sim();
    end
  end

  // ------------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------------
  initial
  begin
    rows = '{
      '{1'b0, 8'h00, 8'h08, 8'h08}, '{1'b0, 8'h05, 8'h80, 8'h80},
      '{1'b0, 8'h0b, 8'hf7, 8'hf7}, '{1'b0, 8'h12, 8'he5, 8'he5},
      '{1'b0, 8'h13, 8'h1b, 8'h1b}, '{1'b0, 8'h14, 8'hc6, 8'hc6},
      '{1'b1, 8'h1c, 8'ha5, 8'ha5}, '{1'b1, 8'h1d, 8'hfd, 8'h0d},
      '{1'b0, 8'h20, 8'h55, 8'h00}, '{1'b0, 8'h1c, 8'h33, 8'h00},
      '{1'b1, 8'h12, 8'h44, 8'h00}};
    repeat (2) tick;
    chk("outs_in_reset", 96'h0, {drive_l, buf_l, span_l});
    repeat (2) @(posedge clk_in);
    #1;
    reset_in = 1'b0;
    chk("level_after_reset", 96'h0, level_l);
    $display("test reset done");
    foreach (rows[i])
    begin
      wr_reg(rows[i].page, rows[i].addr, rows[i].wdata);
      rd_reg(rows[i].page, rows[i].addr);
      chk("rdata", rows[i].rexp, rdata_l);
    end
    tick;
    chk("span", 24'hc61be5, span_l);
    chk("drive", f_drive(12'hda5, 24'hc61be5), drive_l);
    chk("buffer", f_drive(12'hfff, 24'hc61be5), buf_l);
    chk("level", {8'hf7, 40'h0, 8'h80, 32'h0, 8'h08}, level_l);
    chk("small_hi", 16'h0, {drive_s[11:8], buf_s[11:8]});
    tick;
    chk("node", {8'hf7, 80'h0, 8'h08}, {node[95:88], 80'h0, node[7:0]});
    $display("test table done");
    wr_reg(1'b1, 8'h1c, 8'h00);
    tick;
    chk("drive_en0", f_drive(12'hd00, 24'hc61be5), drive_l);
    wr_reg(1'b0, 8'h12, 8'h00);
    tick;
    chk("buffer_off", f_drive(12'hfff, 24'hc61b00), buf_l);
    $display("test disable done");
    reset_in = 1'b1;
    tick;
    chk("outs_mid_reset", 96'h0, {drive_l, buf_l, span_l});
    reset_in = 1'b0;
    boot_rng = 24'hffffff;
    boot = 1'b1;
    tick;
    boot = 1'b0;
    tick;
    chk("boot_span", 24'hffffff, span_l);
    chk("boot_drive", 12'h000, drive_l);
    chk("boot_buffer", 12'hfff, buf_l);
    chk("boot_level", 96'h0, level_l);
    chk("small_span", 24'h00ffff, span_s);
    rd_reg(1'b1, 8'h1c);
    chk("en_after_boot", 8'h00, rdata_l);
    rd_reg(1'b0, 8'h14);
    chk("small_rd14", 8'h00, rdata_s);
    wr_reg(1'b1, 8'h1c, 8'h01);
    tick;
    chk("en_after_write", 12'h001, drive_l);
    $display("test boot done");
    end_sim();
  end
endmodule : tdoc_top_test
`default_nettype wire
